// ==== bench/sri_remote_tx.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// remote transmitter on the receive line
// ****************************************
module sri_remote_tx (
  input wire logic hclk,
  input wire logic tick16,
  input wire logic send,
  input wire logic [7:0] data,
  input wire logic stop_val,
  input wire logic par_en,
  input wire logic par_bad,
  input wire logic ir_on,
  input wire logic invert,
  output logic busy,
  output logic line
);
  logic [10:0] frame_q = '1; // start bit sits at the lsb
  logic [3:0] nbit_q = '0; // bits left in the frame
  logic [3:0] tick_q = '0; // tick within the bit
  logic bit_w; // bit now on the line
  initial busy = 1'h0;
  // load a frame, then shift it out lsb first
  always @(posedge hclk) begin
    if (send && !busy) begin
      // even parity; par_bad flips it on purpose
      frame_q <= par_en ? {stop_val, ^data ^ par_bad, data, 1'h0} : {1'h1, stop_val, data, 1'h0};
      nbit_q <= par_en ? 4'hb : 4'ha;
      tick_q <= 4'h0;
      busy <= 1'h1;
    end else if (busy && tick16) begin
      tick_q <= tick_q + 4'h1;
      // sixteen ticks to a bit
      if (tick_q == 4'hf) begin
        frame_q <= {1'h1, frame_q[10:1]};
        nbit_q <= nbit_q - 4'h1;
        busy <= (nbit_q != 4'h1);
      end
    end
  end
  // a released line is driven high, never holds the last bit
  assign bit_w = busy ? frame_q[0] : 1'h1;
  // infrared: a zero bit is a low pulse over its first three ticks only
  assign line = invert ^ (ir_on ? (bit_w | (tick_q > 4'h2)) : bit_w);
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sri_cfg.svh"
module tb_top;
  import sri_pkg::*;
  // ****************************************
  // bench signals and instances
  // ****************************************
  logic hclk, hresetn, clk_en, hsel, hwrite, tick16, sclk_in_pin;
  logic [17:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, serial_in_pin, serial_out_pin, irq_request;
  sri_prio_t cpu_mask;
  logic [23:0] irq_vector;
  logic send, p_stop, p_bad, p_par, p_ir, p_inv, p_busy;
  logic [7:0] p_data, byte_seen;
  int n_mismatch, n_checks, gap;
  sri_uart i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tick16(tick16),
    .serial_in_pin(serial_in_pin), .sclk_in_pin(sclk_in_pin), .serial_out_pin(serial_out_pin),
    .cpu_mask(cpu_mask), .irq_request(irq_request), .irq_vector(irq_vector));
  sri_remote_tx i_remote (.hclk(hclk), .tick16(tick16), .send(send), .data(p_data), .stop_val(p_stop),
    .par_en(p_par), .par_bad(p_bad), .ir_on(p_ir), .invert(p_inv), .busy(p_busy), .line(serial_in_pin));
  // 20 mhz clock
  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end
  // timer tick every second cycle, so one bit is 32 cycles
  always @(posedge hclk) tick16 <= ~tick16;
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // a wait that runs dry counts as a mismatch and ends the run
  task automatic give_up;
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    close_out();
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // one bus phase, held until hready is seen high at a rising edge
  task automatic phase;
    int n;
    logic rdy;
    n = 0;
    rdy = 1'h0;
    while (!rdy) begin
      @(posedge hclk);
      rdy = hreadyout === 1'h1;
      rd = hrdata;
      n++;
      if (n > 40) give_up();
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    haddr <= {idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    phase();
    htrans <= 2'h0;
    hwdata <= wd;
    phase();
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    bus(1'h1, idx, wd);
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // clear all flags and free the receive buffer
  task automatic rearm;
    wr(`SRI_IDX_FLAG, 32'h7);
    wr(`SRI_IDX_ERR, 32'h7);
    wr(`SRI_IDX_TRIG, 32'h2);
  endtask
  // a low stop bit looks like a new start; let that false word run out
  task automatic rx_drain;
    int n;
    n = 0;
    rd = 32'h2;
    while (rd[1]) begin
      bus(1'h0, `SRI_IDX_TRIG, 32'h0);
      n++;
      if (n > 400) give_up();
    end
  endtask
  task automatic wait_pin(input logic lvl, output int n);
    n = 0;
    while (serial_out_pin !== lvl) begin
      pause(1);
      n++;
      if (n > 2000) give_up();
    end
  endtask
  task automatic rx_frame(input logic [7:0] d, input logic stp, input logic bad);
    int n;
    p_data <= d;
    p_stop <= stp;
    p_bad <= bad;
    send <= 1'h1;
    pause(1);
    send <= 1'h0;
    pause(1);
    n = 0;
    while (p_busy === 1'h1) begin
      pause(1);
      n++;
      if (n > 2000) give_up();
    end
    pause(4);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset;
    chk({7'h0, irq_request, irq_vector}, 32'h0000_001e);
    chk({31'h0, serial_out_pin}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    rchk(`SRI_IDX_PRIO, 32'h0);
    rchk(`SRI_IDX_EN, 32'h0);
    rchk(`SRI_IDX_FLAG, 32'h0);
    rchk(`SRI_IDX_CTRL, 32'h0);
    rchk(`SRI_IDX_ERR, 32'h0);
    wr(16'h0100, 32'hffff_ffff);
    rchk(16'h0100, 32'h0);
  endtask
  // good word, framing error, then overrun
  task automatic s_rx;
    wr(`SRI_IDX_CTRL, 32'h2);
    rx_frame(8'ha5, 1'h1, 1'h0);
    rchk(`SRI_IDX_FLAG, 32'h2);
    rchk(`SRI_IDX_DATA, 32'ha5);
    wr(`SRI_IDX_FLAG, 32'h2);
    rchk(`SRI_IDX_FLAG, 32'h0);
    wr(`SRI_IDX_TRIG, 32'h2);
    rx_frame(8'h3c, 1'h0, 1'h0);
    rchk(`SRI_IDX_FLAG, 32'h3);
    rchk(`SRI_IDX_DATA, 32'h3c);
    wr(`SRI_IDX_ERR, 32'h0);
    rchk(`SRI_IDX_ERR, 32'h4);
    wr(`SRI_IDX_ERR, 32'h4);
    rchk(`SRI_IDX_ERR, 32'h0);
    rx_drain();
    rearm();
    rx_frame(8'h5a, 1'h1, 1'h0);
    rchk(`SRI_IDX_DATA, 32'h5a);
    // buffer not freed, so the next word overruns
    wr(`SRI_IDX_FLAG, 32'h7);
    rx_frame(8'h22, 1'h1, 1'h0);
    rchk(`SRI_IDX_FLAG, 32'h1);
    rchk(`SRI_IDX_ERR, 32'h2);
    rchk(`SRI_IDX_DATA, 32'h22);
    wr(`SRI_IDX_ERR, 32'h2);
    rchk(`SRI_IDX_ERR, 32'h0);
    rearm();
    wr(`SRI_IDX_CTRL, 32'h0);
  endtask
  task automatic s_parity;
    wr(`SRI_IDX_CTRL, 32'ha);
    p_par <= 1'h1;
    rx_frame(8'h0f, 1'h1, 1'h1);
    rchk(`SRI_IDX_ERR, 32'h1);
    rchk(`SRI_IDX_FLAG, 32'h3);
    wr(`SRI_IDX_ERR, 32'h1);
    rchk(`SRI_IDX_ERR, 32'h0);
    rearm();
    rx_frame(8'h07, 1'h1, 1'h0);
    rchk(`SRI_IDX_ERR, 32'h0);
    rchk(`SRI_IDX_DATA, 32'h07);
    rearm();
    wr(`SRI_IDX_CTRL, 32'h0);
    p_par <= 1'h0;
  endtask
  // slave receive on sclk edges; an unread word makes the next overrun
  task automatic s_sync;
    wr(`SRI_IDX_CTRL, 32'h6);
    for (int k = 0; k < 2; k++) begin
      wr(`SRI_IDX_TRIG, 32'h2);
      repeat (8) begin
        sclk_in_pin <= 1'h1;
        pause(2);
        sclk_in_pin <= 1'h0;
        pause(2);
      end
      pause(2);
      rchk(`SRI_IDX_FLAG, (k != 0) ? 32'h1 : 32'h2);
      rchk(`SRI_IDX_ERR, (k != 0) ? 32'h2 : 32'h0);
      wr(`SRI_IDX_FLAG, 32'h7);
    end
    rchk(`SRI_IDX_DATA, 32'hff);
    wr(`SRI_IDX_CTRL, 32'h0);
    rearm();
  endtask
  // priority against mask, enables, vector choice
  task automatic s_irq;
    for (int i = 0; i < 4; i++) begin
      wr(`SRI_IDX_PRIO, 32'(i) << `SRI_PRIO_LSB);
      rchk(`SRI_IDX_PRIO, 32'(i) << `SRI_PRIO_LSB);
    end
    wr(`SRI_IDX_CTRL, 32'h2);
    rx_frame(8'h81, 1'h0, 1'h0);
    wr(`SRI_IDX_PRIO, 32'h20);
    wr(`SRI_IDX_EN, 32'h2);
    cpu_mask <= 2'h1;
    pause(3);
    chk({7'h0, irq_request, irq_vector}, 32'h0100_001c);
    cpu_mask <= 2'h2;
    pause(3);
    chk({31'h0, irq_request}, 32'h0);
    wr(`SRI_IDX_EN, 32'h3);
    cpu_mask <= 2'h1;
    pause(3);
    chk({7'h0, irq_request, irq_vector}, 32'h0100_001a);
    wr(`SRI_IDX_EN, 32'h0);
    pause(3);
    chk({31'h0, irq_request}, 32'h0);
    rchk(`SRI_IDX_FLAG, 32'h3);
    rx_drain();
    rearm();
    wr(`SRI_IDX_CTRL, 32'h0);
  endtask
  // plain transmit, sampled at bit middles
  task automatic s_tx;
    wr(`SRI_IDX_CTRL, 32'h1);
    wr(`SRI_IDX_DATA, 32'hc6);
    wr(`SRI_IDX_EN, 32'h4);
    wr(`SRI_IDX_TRIG, 32'h1);
    wait_pin(1'h0, gap);
    pause(16);
    chk({31'h0, serial_out_pin}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      pause(32);
      byte_seen[i] = serial_out_pin;
    end
    pause(32);
    chk({23'h0, serial_out_pin, byte_seen}, 32'h1c6);
    pause(24);
    chk({7'h0, irq_request, irq_vector}, 32'h0100_001e);
    rchk(`SRI_IDX_FLAG, 32'h4);
    rearm();
    wr(`SRI_IDX_EN, 32'h0);
  endtask
  // infrared pulses and both polarities
  task automatic s_ir;
    wr(`SRI_IDX_CTRL, 32'h41);
    wr(`SRI_IDX_DATA, 32'hfe);
    wr(`SRI_IDX_TRIG, 32'h1);
    wait_pin(1'h0, gap);
    wait_pin(1'h1, gap);
    wait_pin(1'h0, gap);
    chk(32'(gap + 6), 32'h20);
    wait_pin(1'h1, gap);
    chk(32'(gap), 32'h6);
    pause(320);
    rchk(`SRI_IDX_TRIG, 32'h0);
    chk({31'h0, serial_out_pin}, 32'h1);
    wr(`SRI_IDX_FLAG, 32'h7);
    wr(`SRI_IDX_CTRL, 32'h100);
    pause(2);
    chk({31'h0, serial_out_pin}, 32'h0);
    wr(`SRI_IDX_CTRL, 32'h80);
    p_inv <= 1'h1;
    wr(`SRI_IDX_CTRL, 32'h82);
    rx_frame(8'h69, 1'h1, 1'h0);
    rchk(`SRI_IDX_DATA, 32'h69);
    rchk(`SRI_IDX_ERR, 32'h0);
    rearm();
    wr(`SRI_IDX_CTRL, 32'h0);
    p_inv <= 1'h0;
    p_ir <= 1'h1;
    wr(`SRI_IDX_CTRL, 32'h42);
    rx_frame(8'h96, 1'h1, 1'h0);
    rchk(`SRI_IDX_DATA, 32'h96);
  endtask
  initial begin
    {hresetn, clk_en, hsel, hwrite, tick16, sclk_in_pin} = 6'h18;
    {send, p_stop, p_bad, p_par, p_ir, p_inv} = 6'h10;
    haddr = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = '0;
    cpu_mask = 2'h0;
    p_data = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    pause(1);
    s_reset();
    s_rx();
    s_parity();
    s_sync();
    s_irq();
    s_tx();
    s_ir();
    close_out();
  end
endmodule
`default_nettype wire

// ==== rtl/sri_cfg.svh ====
`ifndef SRI_CFG_SVH
`define SRI_CFG_SVH
// ****************************************
// register indices, byte address is index times four
// ****************************************
`define SRI_IDX_PRIO 16'hff21
`define SRI_IDX_EN 16'hff24
`define SRI_IDX_FLAG 16'hff28
`define SRI_IDX_CTRL 16'hff30
`define SRI_IDX_TRIG 16'hff31
`define SRI_IDX_DATA 16'hff32
`define SRI_IDX_ERR 16'hff33
// ****************************************
// field positions
// ****************************************
`define SRI_PRIO_LSB 4
`define SRI_F_ERR 0
`define SRI_F_RX 1
`define SRI_F_TX 2
`define SRI_C_TXEN 0
`define SRI_C_RXEN 1
`define SRI_C_SYNC 2
`define SRI_C_PEN 3
`define SRI_C_PODD 4
`define SRI_C_IRM 5
`define SRI_C_RPOL 7
`define SRI_C_TPOL 8
`define SRI_E_PAR 0
`define SRI_E_OVR 1
`define SRI_E_FRM 2
`define SRI_T_TX 0
`define SRI_T_RX 1
`define SRI_IR_ON 2'h2
// ****************************************
// reset values
// ****************************************
`define SRI_PRIO_RST 2'h0
`define SRI_EN_RST 3'h0
`define SRI_FLAG_RST 3'h0
`define SRI_ERR_RST 3'h0
`define SRI_CTRL_RST 9'h000
// ****************************************
// timing in 16x timer ticks, vectors
// ****************************************
`define SRI_OVS 16
`define SRI_START_CHK (`SRI_OVS / 2)
`define SRI_IR_PULSE 3
`define SRI_VEC_TX 24'h00_001e
`define SRI_VEC_RX 24'h00_001c
`define SRI_VEC_ERR 24'h00_001a
`endif

// ==== rtl/sri_pkg.sv ====
package sri_pkg;
  // receiver sequence
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} sri_rx_state_t;
  // cpu priority and mask level, 0 to 3
  typedef logic [1:0] sri_prio_t;
endpackage

// ==== rtl/sri_ppm.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sri_cfg.svh"
module sri_ppm #(
  parameter int OVS = `SRI_OVS,
  parameter int PULSE = `SRI_IR_PULSE
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic tick16,
  input wire logic ir_on,
  input wire logic tx_bit,
  input wire logic [3:0] tx_phase,
  input wire logic rx_pin,
  output logic tx_line,
  output logic rx_line
);
  localparam int SW = $clog2(OVS + 1);
  logic [SW-1:0] str_q; // stretch count, ticks left of a received pulse
  logic pin_q; // previous pin level, for the pulse edge
  // ****************************************
  // modulator
  // ****************************************
  // a zero bit becomes a short low pulse at the start of the bit
  assign tx_line = (ir_on && !tx_bit) ? (tx_phase >= 4'(PULSE)) : tx_bit;
  // demodulator: each pulse is widened back to one whole bit
  assign rx_line = ir_on ? (str_q == '0) : rx_pin;
  // stretch counter, restarted only on the falling edge of a pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      str_q <= '0;
      pin_q <= 1'b1;
    end else if (clk_en) begin
      pin_q <= rx_pin;
      if (ir_on && pin_q && !rx_pin) begin
        str_q <= SW'(OVS);
      end else if (tick16 && str_q != '0) begin
        str_q <= str_q - SW'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/sri_uart.sv ====
// Notes on behaviour
// - stop bit zero sets framing and error flags
// - write one clears framing flag
// - framed word still buffered, receiving continues
// - async overrun if trigger not yet written
// - sync slave overrun if word not read
// - overrun sets flags, word still buffered
// - write one clears overrun flag
// - buffer load with trigger write counts overrun
// - three sources, enables, one priority level
// - tx done flag, request if enabled, priority
// - factor flags set regardless of enable
// - buffer load sets receive done flag
// - receive done also on parity, framing
// - error flag with receive done, gated likewise
// - overrun raises no receive done flag
// - write one clears any factor flag
// - distinct vector per source
// - error vector wins over receive done
// - mode field 10 infrared, 00 normal
// - reset selects normal interface
// - receive polarity one inverts input
// - transmit polarity one inverts output
// - both polarity bits reset to zero
// - infrared pulse three sixteenths of bit
// - parity checked at buffer load
// - write one clears parity flag
// - bit timing is 16x tick divided
`timescale 1ns/100ps
`default_nettype none
`include "sri_cfg.svh"
module sri_uart #(
  parameter int ADDR_W = 18
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tick16,
  input wire logic serial_in_pin,
  input wire logic sclk_in_pin,
  output logic serial_out_pin,
  input wire sri_pkg::sri_prio_t cpu_mask,
  output logic irq_request,
  output logic [23:0] irq_vector
);
  import sri_pkg::*;

  // expected parity bit of a byte
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // ****************************************
  // bus slave
  // ****************************************
  logic wr_q; // write data phase pending
  logic rd_q; // read wait cycle
  logic [15:0] idx_q; // latched register index
  logic [31:0] hrdata_q;
  logic [31:0] rd_word;
  wire take = hsel && htrans[1] && hready && clk_en;
  // reads take one wait state so a write just before is seen
  assign hreadyout = clk_en && !rd_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // address phase capture and read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 16'h0000;
      hrdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      if (take) begin
        idx_q <= haddr[17:2];
      end
      if (rd_q) begin
        hrdata_q <= rd_word;
      end
    end
  end

  // strobes of the write data phase
  wire w_prio = wr_q && (idx_q == `SRI_IDX_PRIO);
  wire w_en = wr_q && (idx_q == `SRI_IDX_EN);
  wire w_flag = wr_q && (idx_q == `SRI_IDX_FLAG);
  wire w_ctrl = wr_q && (idx_q == `SRI_IDX_CTRL);
  wire w_trig = wr_q && (idx_q == `SRI_IDX_TRIG);
  wire w_data = wr_q && (idx_q == `SRI_IDX_DATA);
  wire w_err = wr_q && (idx_q == `SRI_IDX_ERR);
  wire r_data = rd_q && (idx_q == `SRI_IDX_DATA);
  wire tx_trig = w_trig && hwdata[`SRI_T_TX];
  wire rx_trig = w_trig && hwdata[`SRI_T_RX];

  // ****************************************
  // registers
  // ****************************************
  sri_prio_t prio_q; // shared priority level
  logic [2:0] en_q; // source enables
  logic [2:0] flags_q; // factor flags
  logic [2:0] err_q; // parity, overrun, framing
  logic [8:0] ctrl_q; // mode and enables
  logic [7:0] tx_data_q; // word to send
  logic [7:0] rx_buf_q; // receive data buffer
  logic oercs_q; // buffer not yet released by trigger
  logic unread_q; // buffer not yet read
  logic [2:0] flag_set;
  logic [2:0] err_set;
  logic rx_cmp;
  logic tx_cmp;
  logic tx_busy_q;
  logic rx_busy;
  logic [7:0] rx_data;

  // control fields
  wire tx_en = ctrl_q[`SRI_C_TXEN];
  wire rx_en = ctrl_q[`SRI_C_RXEN];
  wire sync_md = ctrl_q[`SRI_C_SYNC];
  wire par_en = ctrl_q[`SRI_C_PEN];
  wire par_odd = ctrl_q[`SRI_C_PODD];
  wire [1:0] ir_mode = ctrl_q[`SRI_C_IRM+:2];
  wire rx_pol = ctrl_q[`SRI_C_RPOL];
  wire tx_pol = ctrl_q[`SRI_C_TPOL];
  // reserved codes act as normal mode; sync mode never modulates
  wire ir_on = (ir_mode == `SRI_IR_ON) && !sync_md;

  // read selection, unmapped indices read zero
  assign rd_word =
    (idx_q == `SRI_IDX_PRIO) ? (32'(prio_q) << `SRI_PRIO_LSB) :
    (idx_q == `SRI_IDX_EN) ? 32'(en_q) :
    (idx_q == `SRI_IDX_FLAG) ? 32'(flags_q) :
    (idx_q == `SRI_IDX_CTRL) ? 32'(ctrl_q) :
    (idx_q == `SRI_IDX_TRIG) ? ((32'(rx_busy) << `SRI_T_RX) | (32'(tx_busy_q) << `SRI_T_TX)) :
    (idx_q == `SRI_IDX_DATA) ? 32'(rx_buf_q) :
    (idx_q == `SRI_IDX_ERR) ? 32'(err_q) : 32'h0000_0000;

  // software registers; hardware sets win over write-one clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio_q <= `SRI_PRIO_RST;
      en_q <= `SRI_EN_RST;
      flags_q <= `SRI_FLAG_RST;
      err_q <= `SRI_ERR_RST;
      ctrl_q <= `SRI_CTRL_RST;
      tx_data_q <= 8'h00;
      rx_buf_q <= 8'h00;
      oercs_q <= 1'b0;
      unread_q <= 1'b0;
    end else if (clk_en) begin
      if (w_prio) begin
        prio_q <= hwdata[`SRI_PRIO_LSB+:2];
      end
      if (w_en) begin
        en_q <= hwdata[2:0];
      end
      if (w_ctrl) begin
        ctrl_q <= hwdata[8:0];
      end
      if (w_data) begin
        tx_data_q <= hwdata[7:0];
      end
      flags_q <= (flags_q & ~(w_flag ? hwdata[2:0] : 3'h0)) | flag_set;
      err_q <= (err_q & ~(w_err ? hwdata[2:0] : 3'h0)) | err_set;
      if (rx_cmp) begin
        rx_buf_q <= rx_data;
      end
      // release marker: completion sets, trigger write clears
      oercs_q <= (oercs_q && !rx_trig) || (rx_cmp && !sync_md);
      unread_q <= (unread_q && !r_data) || (rx_cmp && sync_md);
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  sri_rx_state_t rx_st_q;
  logic [3:0] rx_ph_q; // tick phase within a bit
  logic [3:0] rx_cnt_q; // bits taken so far
  logic [8:0] rx_sh_q; // shift register, lsb first
  logic sclk_q; // previous sync clock level
  logic rx_line; // line after polarity and demodulation
  wire rx_in = serial_in_pin ^ rx_pol;
  wire sclk_rise = sclk_in_pin && !sclk_q;
  wire with_par = par_en && !sync_md;
  wire [3:0] rx_nbits = with_par ? 4'h9 : 4'h8;
  wire bit_tick = tick16 && (rx_ph_q == 4'hf);
  wire rx_take = sync_md ? sclk_rise : bit_tick;

  assign rx_busy = (rx_st_q != RX_IDLE);
  assign rx_data = with_par ? rx_sh_q[7:0] : rx_sh_q[8:1];
  // sync words finish one cycle after the last bit; async at stop mid
  assign rx_cmp = (rx_st_q == RX_STOP) && (sync_md || bit_tick);
  wire frm_err = !sync_md && !rx_line;
  wire par_err = with_par && (rx_sh_q[8] != par_of(rx_sh_q[7:0], par_odd));
  wire ovr = sync_md ? unread_q : oercs_q;

  // event sets for factor and error flags
  assign err_set[`SRI_E_FRM] = rx_cmp && frm_err;
  assign err_set[`SRI_E_PAR] = rx_cmp && par_err;
  assign err_set[`SRI_E_OVR] = rx_cmp && ovr;
  assign flag_set[`SRI_F_ERR] = rx_cmp && (frm_err || par_err || ovr);
  assign flag_set[`SRI_F_RX] = rx_cmp && !ovr;
  assign flag_set[`SRI_F_TX] = tx_cmp;

  // receive sequence; a start that fails its mid check is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q <= RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      sclk_q <= 1'b0;
    end else if (clk_en) begin
      sclk_q <= sclk_in_pin;
      if (tick16) begin
        rx_ph_q <= rx_ph_q + 4'h1;
      end
      case (rx_st_q)
        RX_IDLE: begin
          rx_ph_q <= 4'h0;
          rx_cnt_q <= 4'h0;
          if (rx_en && sync_md && rx_trig) begin
            rx_st_q <= RX_BITS;
          end else if (rx_en && !sync_md && !rx_line) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          // half a bit in, the line must still be low
          if (tick16 && rx_ph_q == 4'(`SRI_START_CHK - 1)) begin
            rx_ph_q <= 4'h0;
            rx_st_q <= rx_line ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_take) begin
            rx_sh_q <= {rx_line, rx_sh_q[8:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == rx_nbits - 4'h1) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // word is buffered whatever errors it carries
          if (rx_cmp) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // transmitter, asynchronous frames only
  // ****************************************
  logic [10:0] tx_sh_q; // frame, start bit first
  logic [3:0] tx_ph_q; // tick phase within a bit
  logic [3:0] tx_cnt_q; // bits sent
  logic [3:0] tx_nbits_q; // frame length
  logic tx_mod; // line after modulator
  wire tx_start = tx_trig && tx_en && !tx_busy_q && !sync_md;
  wire tx_bit = tx_busy_q ? tx_sh_q[0] : 1'b1;
  assign tx_cmp = tx_busy_q && tick16 && (tx_ph_q == 4'hf) && (tx_cnt_q == tx_nbits_q - 4'h1);

  // a trigger while busy is ignored, not queued
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 11'h7ff;
      tx_ph_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_nbits_q <= 4'ha;
    end else if (clk_en) begin
      if (tx_start) begin
        tx_busy_q <= 1'b1;
        tx_ph_q <= 4'h0;
        tx_cnt_q <= 4'h0;
        tx_sh_q <= {1'b1, par_en ? par_of(tx_data_q, par_odd) : 1'b1, tx_data_q, 1'b0};
        tx_nbits_q <= par_en ? 4'hb : 4'ha;
      end else if (tx_busy_q && tick16) begin
        tx_ph_q <= tx_ph_q + 4'h1;
        if (tx_ph_q == 4'hf) begin
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          tx_cnt_q <= tx_cnt_q + 4'h1;
          if (tx_cmp) begin
            tx_busy_q <= 1'b0;
          end
        end
      end
    end
  end

  // pulse shaping both ways
  sri_ppm u_ppm (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .tick16(tick16),
    .ir_on(ir_on),
    .tx_bit(tx_bit),
    .tx_phase(tx_ph_q),
    .rx_pin(rx_in),
    .tx_line(tx_mod),
    .rx_line(rx_line)
  );

  // ****************************************
  // output pin and cpu request
  // ****************************************
  wire [2:0] pend = flags_q & en_q;
  wire irq_d = (|pend) && (prio_q > cpu_mask);
  // error first, then receive done, then transmit done
  wire [23:0] vec_d = pend[`SRI_F_ERR] ? `SRI_VEC_ERR :
                      pend[`SRI_F_RX] ? `SRI_VEC_RX : `SRI_VEC_TX;

  // registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out_pin <= 1'b1;
      irq_request <= 1'b0;
      irq_vector <= `SRI_VEC_TX;
    end else if (clk_en) begin
      serial_out_pin <= tx_mod ^ tx_pol;
      irq_request <= irq_d;
      irq_vector <= vec_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_tx_cmp_open;
    clk_en && tx_cmp && en_q[`SRI_F_TX] && (prio_q > cpu_mask);
  endsequence
  sequence s_still_open;
    clk_en && en_q[`SRI_F_TX] && (prio_q > cpu_mask);
  endsequence

  property p_frm_flags;
    clk_en && rx_cmp && frm_err |=> err_q[`SRI_E_FRM] && flags_q[`SRI_F_ERR];
  endproperty
  a_frm_flags: assert property (p_frm_flags) else $error("framing flags not set");

  property p_frm_clear;
    clk_en && w_err && hwdata[`SRI_E_FRM] && !err_set[`SRI_E_FRM] |=> !err_q[`SRI_E_FRM];
  endproperty
  a_frm_clear: assert property (p_frm_clear) else $error("framing flag not cleared");

  property p_buf_load;
    clk_en && rx_cmp |=> rx_buf_q == $past(rx_data);
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("word not buffered");

  property p_ovr_async;
    clk_en && rx_cmp && !sync_md && oercs_q |=> err_q[`SRI_E_OVR] && flags_q[`SRI_F_ERR];
  endproperty
  a_ovr_async: assert property (p_ovr_async) else $error("overrun missed");

  property p_ovr_same_cycle;
    clk_en && rx_cmp && !sync_md && oercs_q && rx_trig |=> err_q[`SRI_E_OVR];
  endproperty
  a_ovr_same_cycle: assert property (p_ovr_same_cycle) else $error("trigger collision not overrun");

  property p_no_rx_on_ovr;
    clk_en && rx_cmp && ovr && !flags_q[`SRI_F_RX] |=> !flags_q[`SRI_F_RX];
  endproperty
  a_no_rx_on_ovr: assert property (p_no_rx_on_ovr) else $error("receive done on overrun");

  property p_tx_irq;
    s_tx_cmp_open ##1 s_still_open |=> irq_request;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit request missing");

  property p_flag_no_en;
    clk_en && tx_cmp && !en_q[`SRI_F_TX] |=> flags_q[`SRI_F_TX];
  endproperty
  a_flag_no_en: assert property (p_flag_no_en) else $error("factor flag gated by enable");

  property p_err_vector;
    clk_en && pend[`SRI_F_ERR] |=> irq_vector == `SRI_VEC_ERR;
  endproperty
  a_err_vector: assert property (p_err_vector) else $error("error vector not first");

  property p_par_flag;
    clk_en && rx_cmp && par_err && !ovr |=> err_q[`SRI_E_PAR] && flags_q[`SRI_F_RX];
  endproperty
  a_par_flag: assert property (p_par_flag) else $error("parity flags not set");

  property p_ir_idle;
    clk_en && ir_on && tx_busy_q && (tx_ph_q >= 4'(`SRI_IR_PULSE)) |=> serial_out_pin == $past(!tx_pol);
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("infrared pulse too long");
endmodule
`default_nettype wire
